// >>> tpo_pkg.sv
// Shared constants, types and helpers of the PWM and one-shot timer group.
package tpo_pkg;
	localparam int          ADDR_W     = 4;
	localparam int          DATA_W     = 16;
	localparam int          CNT_W      = 16;
	// Register word offsets.
	localparam logic [3:0]  OFS_CTL0   = 4'h0;
	localparam logic [3:0]  OFS_CTL1   = 4'h1;
	localparam logic [3:0]  OFS_IOC0   = 4'h2;
	localparam logic [3:0]  OFS_IOC1   = 4'h3;
	localparam logic [3:0]  OFS_IOC2   = 4'h4;
	localparam logic [3:0]  OFS_OPT0   = 4'h5;
	localparam logic [3:0]  OFS_CCR0   = 4'h6;
	localparam logic [3:0]  OFS_CCR3   = 4'h9;
	localparam logic [3:0]  OFS_CNT    = 4'hA;
	// Field positions.
	localparam int          CE_BIT     = 7;
	localparam int          CKS_LSB    = 0;
	localparam int          MODE_LSB   = 0;
	localparam int          SWTRIG_BIT = 6;
	localparam int          EES_LSB    = 2;
	localparam int          ETS_LSB    = 0;
	// Reset values.
	localparam logic [7:0]  RST_REG8   = 8'h00;
	localparam logic [15:0] RST_CCR    = 16'h0000;
	// Encodings.
	localparam logic [2:0]  MODE_ONESHOT = 3'h3;
	localparam logic [2:0]  MODE_PWM     = 3'h4;
	localparam logic [2:0]  CKS_EXT      = 3'h7;
	localparam logic [1:0]  EDGE_NONE    = 2'h0;
	localparam logic [1:0]  EDGE_RISE    = 2'h1;
	localparam logic [1:0]  EDGE_FALL    = 2'h2;
	localparam logic [15:0] CNT_IDLE     = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO     = 16'h0000;
	localparam int          PRE_W        = 7;

	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} tpo_state_type;

	// True when the selected edge shows between the previous and current level.
	function automatic logic tpo_edge_hit(input logic [1:0] sel, input logic prev,
		input logic cur);
		logic rise;
		logic fall;
		rise = cur & ~prev;
		fall = prev & ~cur;
		case (sel)
			EDGE_NONE: tpo_edge_hit = 1'b0;
			EDGE_RISE: tpo_edge_hit = rise;
			EDGE_FALL: tpo_edge_hit = fall;
			default:   tpo_edge_hit = rise | fall;
		endcase
	endfunction
endpackage

// >>> tpo_link_if.sv
// Interface joining the timer core with its prescaler and pin driver.
interface tpo_link_if;
	logic       tick;      // Count clock pulse.
	logic [2:0] cks;       // Count clock select.
	logic [1:0] ees;       // Event edge select.
	logic       ext_event; // External event level.
	logic [3:0] raw;       // Unpolarised output levels.
	logic [3:0] ol;        // Output level bits.
	logic [3:0] oe;        // Output enable bits.
	logic [3:0] pin;       // Pin levels.
	logic [3:0] pin_oe;    // Pin drive enables.
	modport pre  (input cks, ees, ext_event, output tick);
	modport core (output cks, ees, ext_event, raw, ol, oe, input tick, pin, pin_oe);
	modport drv  (input raw, ol, oe, output pin, pin_oe);
endinterface

// >>> tpo_prescale.sv
// Count clock generator: binary divider or external event edges.
module tpo_prescale (
	input  wire logic clock_in, // System clock.
	input  wire logic nrst_in,  // Asynchronous reset, active low.
	tpo_link_if.pre   link      // Link to the core.
);
	logic [tpo_pkg::PRE_W-1:0] div_ff;
	logic                      event_prev_ff;
	logic                      tick_ff;
	logic [tpo_pkg::PRE_W-1:0] mask;

	// Divide by two to the power of the select; select zero ticks every clock.
	assign mask = tpo_pkg::PRE_W'((8'h01 << link.cks) - 8'h01);

	// Free-running divider keeps all rates phase related.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			div_ff <= '0;
		end else begin
			div_ff <= div_ff + tpo_pkg::PRE_W'(1);
		end
	end

	// Event level history for edge detection.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			event_prev_ff <= 1'b0;
		end else begin
			event_prev_ff <= link.ext_event;
		end
	end

	// Tick selection; the select is read live so it may change with the enable.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tick_ff <= 1'b0;
		end else if (link.cks == tpo_pkg::CKS_EXT) begin
			tick_ff <= tpo_pkg::tpo_edge_hit(link.ees, event_prev_ff, link.ext_event); // R14
		end else begin
			tick_ff <= ((div_ff & mask) == mask); // R17
		end
	end

	assign link.tick = tick_ff;
endmodule

// >>> tpo_outdrv.sv
// Pin stage: enable gating of the four timer outputs and polarity of outputs one to three.
module tpo_outdrv (
	input  wire logic clock_in, // System clock.
	input  wire logic nrst_in,  // Asynchronous reset, active low.
	tpo_link_if.drv   link      // Link to the core.
);
	logic [3:0] pin_ff;
	logic [3:0] pin_oe_ff;

	// Output zero shows its level bit while disabled; outputs one to three float.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pin_ff    <= 4'h0;
			pin_oe_ff <= 4'h0;
		end else begin
			pin_ff[0]      <= link.oe[0] ? link.raw[0] : link.ol[0]; // R13
			pin_oe_ff[0]   <= 1'b1;
			pin_ff[3:1]    <= link.oe[3:1] & (link.raw[3:1] ^ link.ol[3:1]); // R12
			pin_oe_ff[3:1] <= link.oe[3:1]; // R12
		end
	end

	assign link.pin    = pin_ff;
	assign link.pin_oe = pin_oe_ff;

	// A disabled output one never drives its pin.
	pin_gate_a: assert property (@(posedge clock_in) disable iff (!nrst_in) // R12
		!link.oe[1] |=> !link.pin_oe[1])
		else $error("Output one driven while disabled.");
endmodule

// >>> tpo_timer.sv
// Timer core with PWM and one-shot outputs, registers and counter.
// Functional notes
// R1: Mode field 100 selects PWM; count enable drives outputs one to three.
// R2: Output zero toggles at every PWM cycle end, period two cycles.
// R3: Enabling PWM moves counter FFFFH to 0000H, then counts up.
// R4: Each PWM output is active for its compare value in count cycles.
// R5: PWM period is period compare plus one; counter clears after match.
// R6: PWM compare writes reach buffers only when the counter clears.
// R7: Period match interrupt comes on the clearing count edge.
// R8: Channel match interrupts come when the counter equals the compare.
// R9: Channel two and three values transfer only after channel one write.
// R10: Software writes period, two and three first, channel one last.
// R11: Changing output one duty needs only the channel one write.
// R12: Enable bit gates each pin; level bit sets polarity of outputs one to three.
// R13: Disabled output zero sits at its level bit.
// R14: Second I/O control selects event edge; trigger edge stays zero in PWM.
// R15: Counter read register returns the live counter.
// R16: Capture edge and option registers have no effect in PWM.
// R17: Clock select may be written together with count enable.
// R18: Software stops counting before lowering one-shot compare values.
// R19: One-shot compares apply at once; a missed value wraps via FFFFH.
// R20: One-shot match k asserts output k; period match ends the pulse.
// R21: Compare zero gives always inactive, period plus one always active.
// R22: Software sets registers before enabling and clears enable to stop.
module tpo_timer (
	input  wire logic                         clock_in,              // System clock, 20 MHz.
	input  wire logic                         nrst_in,               // Reset, active low.
	input  wire logic [tpo_pkg::ADDR_W-1:0]   addr_in,               // Register word offset.
	input  wire logic [tpo_pkg::DATA_W-1:0]   wdata_in,              // Write data.
	input  wire logic                         wr_in,                 // Write strobe.
	input  wire logic                         rd_in,                 // Read strobe.
	output logic      [tpo_pkg::DATA_W-1:0]   rdata_out,             // Read data, next cycle.
	input  wire logic                         event_in,              // External event count input.
	input  wire logic                         trigger_in,            // External trigger input.
	output logic      [3:0]                   pin_out,               // Output pin levels.
	output logic      [3:0]                   pin_oe_out,            // Output pin enables.
	output logic                              period_match_irq_out,  // Period match pulse.
	output logic      [3:1]                   channel_match_irq_out  // Channel match pulses.
);
	tpo_link_if link ();

	logic [7:0]                 ctl0_ff;
	logic [7:0]                 ctl1_ff;
	logic [7:0]                 ioc0_ff;
	logic [7:0]                 ioc1_ff;
	logic [7:0]                 ioc2_ff;
	logic [7:0]                 opt0_ff;
	logic [tpo_pkg::CNT_W-1:0]  ccr_ff [4];
	logic [tpo_pkg::CNT_W-1:0]  buf_ff [4];
	logic [tpo_pkg::CNT_W-1:0]  cnt_ff;
	logic [tpo_pkg::DATA_W-1:0] rdata_ff;
	logic                       arm_ff;
	logic                       trig_prev_ff;
	logic                       toggle_ff;
	logic [3:1]                 raw_ff;
	logic                       period_irq_ff;
	logic [3:1]                 chan_irq_ff;
	tpo_pkg::tpo_state_type     state_ff;
	tpo_pkg::tpo_state_type     nxt_state;
	logic                       ce;
	logic [2:0]                 mode;
	logic                       is_pwm;
	logic                       is_one;
	logic                       running;
	logic                       tick;
	logic                       start;
	logic                       sw_trig;
	logic                       hw_trig;
	logic                       match0;
	logic                       transfer;
	logic [3:1]                 match;

	// Control decode.
	assign ce      = ctl0_ff[tpo_pkg::CE_BIT];
	assign mode    = ctl1_ff[tpo_pkg::MODE_LSB +: 3];
	assign is_pwm  = (mode == tpo_pkg::MODE_PWM); // R1
	assign is_one  = (mode == tpo_pkg::MODE_ONESHOT);
	assign running = (state_ff == tpo_pkg::ST_RUN);
	assign tick    = link.tick;
	assign start   = (state_ff == tpo_pkg::ST_IDLE) && ce;

	// Software trigger is a write-one pulse; it reads back as zero.
	assign sw_trig = wr_in && (addr_in == tpo_pkg::OFS_CTL1) && wdata_in[tpo_pkg::SWTRIG_BIT];
	// The trigger edge is honoured only in one-shot mode, so PWM ignores it.
	assign hw_trig = is_one && tpo_pkg::tpo_edge_hit(ioc2_ff[tpo_pkg::ETS_LSB +: 2], // R14
		trig_prev_ff, trigger_in);

	// PWM compares against buffers, one-shot against the live registers.
	assign match0 = tick && (cnt_ff == (is_pwm ? buf_ff[0] : ccr_ff[0])); // R19
	always_comb begin
		for (int k = 1; k < 4; k++) begin
			match[k] = tick && (cnt_ff == (is_pwm ? buf_ff[k] : ccr_ff[k]));
		end
	end

	// Buffers reload at the clearing edge only when channel one was written.
	assign transfer = running && is_pwm && match0 && arm_ff; // R6 R9

	// Capture-edge and option registers are stored for readback only.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctl0_ff <= tpo_pkg::RST_REG8;
			ctl1_ff <= tpo_pkg::RST_REG8;
			ioc0_ff <= tpo_pkg::RST_REG8;
			ioc1_ff <= tpo_pkg::RST_REG8;
			ioc2_ff <= tpo_pkg::RST_REG8;
			opt0_ff <= tpo_pkg::RST_REG8;
		end else if (wr_in) begin
			case (addr_in)
				tpo_pkg::OFS_CTL0: ctl0_ff <= wdata_in[7:0]; // R17
				tpo_pkg::OFS_CTL1: ctl1_ff <= wdata_in[7:0] & ~(8'h01 << tpo_pkg::SWTRIG_BIT);
				tpo_pkg::OFS_IOC0: ioc0_ff <= wdata_in[7:0];
				tpo_pkg::OFS_IOC1: ioc1_ff <= wdata_in[7:0]; // R16
				tpo_pkg::OFS_IOC2: ioc2_ff <= wdata_in[7:0];
				tpo_pkg::OFS_OPT0: opt0_ff <= wdata_in[7:0]; // R16
				default: ;
			endcase
		end
	end

	// Compare registers; in one-shot mode these are used directly.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			for (int k = 0; k < 4; k++) begin
				ccr_ff[k] <= tpo_pkg::RST_CCR;
			end
		end else if (wr_in && addr_in >= tpo_pkg::OFS_CCR0 && addr_in <= tpo_pkg::OFS_CCR3) begin
			ccr_ff[2'(addr_in - tpo_pkg::OFS_CCR0)] <= wdata_in;
		end
	end

	// Transfer arm: a channel one write sets it and a new write beats the clear.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			arm_ff <= 1'b0;
		end else if (wr_in && addr_in == tpo_pkg::OFS_CCR0 + 4'h1) begin
			arm_ff <= 1'b1; // R9
		end else if (transfer || start) begin
			arm_ff <= 1'b0;
		end
	end

	// Compare buffers: loaded at start, then only at an armed period match.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			for (int k = 0; k < 4; k++) begin
				buf_ff[k] <= tpo_pkg::RST_CCR;
			end
		end else if (start || transfer) begin
			for (int k = 0; k < 4; k++) begin
				buf_ff[k] <= ccr_ff[k]; // R6
			end
		end
	end

	// Trigger input history.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			trig_prev_ff <= 1'b0;
		end else begin
			trig_prev_ff <= trigger_in;
		end
	end

	// Sequencer: PWM runs at once, one-shot waits for a trigger.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			tpo_pkg::ST_IDLE: begin
				if (ce && is_pwm) begin
					nxt_state = tpo_pkg::ST_RUN; // R1
				end else if (ce && is_one) begin
					nxt_state = tpo_pkg::ST_WAIT;
				end
			end
			tpo_pkg::ST_WAIT: begin
				if (!ce) begin
					nxt_state = tpo_pkg::ST_IDLE;
				end else if (sw_trig || hw_trig) begin
					nxt_state = tpo_pkg::ST_RUN;
				end
			end
			tpo_pkg::ST_RUN: begin
				if (!ce) begin
					nxt_state = tpo_pkg::ST_IDLE; // R22
				end else if (is_one && match0) begin
					nxt_state = tpo_pkg::ST_WAIT; // R20
				end
			end
			default: nxt_state = tpo_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_ff <= tpo_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Counter parks at FFFFH so the first tick of a run lands on 0000H.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt_ff <= tpo_pkg::CNT_IDLE;
		end else if (!running || !ce) begin
			cnt_ff <= tpo_pkg::CNT_IDLE; // R3
		end else if (match0 && is_pwm) begin
			cnt_ff <= tpo_pkg::CNT_ZERO; // R5
		end else if (match0 && is_one) begin
			cnt_ff <= tpo_pkg::CNT_IDLE; // R20
		end else if (tick) begin
			cnt_ff <= cnt_ff + tpo_pkg::CNT_W'(1); // R19
		end
	end

	// Output zero: toggles per PWM cycle, or shows the one-shot busy level.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			toggle_ff <= 1'b0;
		end else if (!running || !ce) begin
			toggle_ff <= 1'b0;
		end else if (is_pwm) begin
			toggle_ff <= toggle_ff ^ match0; // R2
		end else begin
			toggle_ff <= !match0;
		end
	end

	// Outputs one to three; PWM by comparison so zero and period plus one saturate.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			raw_ff <= 3'h0;
		end else begin
			for (int k = 1; k < 4; k++) begin
				if (!running || !ce) begin
					raw_ff[k] <= 1'b0;
				end else if (is_pwm) begin
					raw_ff[k] <= (cnt_ff < buf_ff[k]); // R4 R21
				end else if (match0) begin
					raw_ff[k] <= 1'b0; // R20
				end else if (match[k]) begin
					raw_ff[k] <= 1'b1; // R20
				end
			end
		end
	end

	// Interrupt pulses; channel pulses line up with the output change in one-shot mode and in PWM at clock select zero.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			period_irq_ff <= 1'b0;
			chan_irq_ff   <= 3'h0;
		end else begin
			period_irq_ff <= running && ce && match0; // R7
			chan_irq_ff   <= (running && ce) ? match : 3'h0; // R8
		end
	end

	// Read port answers in the next cycle; unmapped offsets read zero.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_ff <= '0;
		end else if (rd_in) begin
			case (addr_in)
				tpo_pkg::OFS_CTL0: rdata_ff <= {8'h00, ctl0_ff};
				tpo_pkg::OFS_CTL1: rdata_ff <= {8'h00, ctl1_ff};
				tpo_pkg::OFS_IOC0: rdata_ff <= {8'h00, ioc0_ff};
				tpo_pkg::OFS_IOC1: rdata_ff <= {8'h00, ioc1_ff};
				tpo_pkg::OFS_IOC2: rdata_ff <= {8'h00, ioc2_ff};
				tpo_pkg::OFS_OPT0: rdata_ff <= {8'h00, opt0_ff};
				tpo_pkg::OFS_CNT:  rdata_ff <= cnt_ff; // R15
				default: begin
					if (addr_in >= tpo_pkg::OFS_CCR0 && addr_in <= tpo_pkg::OFS_CCR3) begin
						rdata_ff <= ccr_ff[2'(addr_in - tpo_pkg::OFS_CCR0)];
					end else begin
						rdata_ff <= '0;
					end
				end
			endcase
		end
	end

	// Link wiring to prescaler and pin stage.
	assign link.cks       = ctl0_ff[tpo_pkg::CKS_LSB +: 3];
	assign link.ees       = ioc2_ff[tpo_pkg::EES_LSB +: 2];
	assign link.ext_event = event_in;
	assign link.raw       = {raw_ff, toggle_ff};
	assign link.ol        = {ioc0_ff[7], ioc0_ff[5], ioc0_ff[3], ioc0_ff[1]};
	assign link.oe        = {ioc0_ff[6], ioc0_ff[4], ioc0_ff[2], ioc0_ff[0]};

	tpo_prescale u_pre (
		.clock_in (clock_in),
		.nrst_in  (nrst_in),
		.link     (link)
	);

	tpo_outdrv u_drv (
		.clock_in (clock_in),
		.nrst_in  (nrst_in),
		.link     (link)
	);

	assign pin_out               = link.pin;
	assign pin_oe_out            = link.pin_oe;
	assign rdata_out             = rdata_ff;
	assign period_match_irq_out  = period_irq_ff;
	assign channel_match_irq_out = chan_irq_ff;

	// A running PWM counter returns to zero after a period match.
	pwm_clear_a: assert property (@(posedge clock_in) disable iff (!nrst_in) // R5
		running && ce && is_pwm && tick && cnt_ff == buf_ff[0] |=> cnt_ff == tpo_pkg::CNT_ZERO)
		else $error("PWM counter did not clear on period match.");

	// The first tick of a PWM run moves the parked counter to zero.
	start_wrap_a: assert property (@(posedge clock_in) disable iff (!nrst_in) // R3
		running && ce && is_pwm && tick && cnt_ff == tpo_pkg::CNT_IDLE && buf_ff[0] != cnt_ff
		|=> cnt_ff == tpo_pkg::CNT_ZERO)
		else $error("PWM start did not wrap to zero.");

	// The period interrupt accompanies the clearing edge.
	period_irq_a: assert property (@(posedge clock_in) disable iff (!nrst_in) // R7
		running && ce && is_pwm && tick && cnt_ff == buf_ff[0]
		|=> period_match_irq_out && cnt_ff == tpo_pkg::CNT_ZERO)
		else $error("Period interrupt missing at counter clear.");

	// Channel one interrupt in the cycle after the counter equals its compare.
	chan_irq_a: assert property (@(posedge clock_in) disable iff (!nrst_in) // R8
		running && ce && is_pwm && tick && cnt_ff == buf_ff[1] |=> channel_match_irq_out[1])
		else $error("Channel one interrupt missing on match.");

	// Output zero flips exactly at period interrupts in PWM mode.
	toggle_half_a: assert property (@(posedge clock_in) disable iff (!nrst_in) // R2
		running && ce && is_pwm && $past(running) |->
		(toggle_ff != $past(toggle_ff)) == period_irq_ff)
		else $error("Output zero toggle not tied to PWM cycle end.");

	// Buffer two holds between clearing edges of a run.
	buffer_hold_a: assert property (@(posedge clock_in) disable iff (!nrst_in) // R6
		running && !transfer |=> $stable(buf_ff[2]))
		else $error("Compare buffer changed outside a counter clear.");

	// No buffer three reload at a PWM period match without a prior channel one write.
	arm_gate_a: assert property (@(posedge clock_in) disable iff (!nrst_in) // R9
		running && is_pwm && match0 && !arm_ff |=> $stable(buf_ff[3]))
		else $error("Buffers reloaded without channel one write.");

	// One-shot period match parks the counter and drops the outputs.
	oneshot_stop_a: assert property (@(posedge clock_in) disable iff (!nrst_in) // R20
		running && ce && is_one && match0
		|=> cnt_ff == tpo_pkg::CNT_IDLE && state_ff == tpo_pkg::ST_WAIT && raw_ff == 3'h0)
		else $error("One-shot pulse did not end on period match.");

	// Counter reads return the value held at the strobe.
	read_cnt_a: assert property (@(posedge clock_in) disable iff (!nrst_in) // R15
		rd_in && addr_in == tpo_pkg::OFS_CNT |=> rdata_out == $past(cnt_ff))
		else $error("Counter read returned a wrong value.");
endmodule

// >>> tpo_timer_test.sv
// Self-checking testbench of the PWM and one-shot timer core.
module tpo_timer_test;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clock_in;
	logic        nrst_in;
	logic [3:0]  addr_in;
	logic [15:0] wdata_in;
	logic        wr_in;
	logic        rd_in;
	logic [15:0] rdata_out;
	logic        event_in;
	logic        trigger_in;
	logic [3:0]  pin_out;
	logic [3:0]  pin_oe_out;
	logic        period_match_irq_out;
	logic [3:1]  channel_match_irq_out;
	logic [15:0] hits [8];
	logic [15:0] rval;
	int          n_fail;
	int          compares;

	tpo_timer tpo_timer_i (
		.clock_in              (clock_in),
		.nrst_in               (nrst_in),
		.addr_in               (addr_in),
		.wdata_in              (wdata_in),
		.wr_in                 (wr_in),
		.rd_in                 (rd_in),
		.rdata_out             (rdata_out),
		.event_in              (event_in),
		.trigger_in            (trigger_in),
		.pin_out               (pin_out),
		.pin_oe_out            (pin_oe_out),
		.period_match_irq_out  (period_match_irq_out),
		.channel_match_irq_out (channel_match_irq_out)
	);

	// A 50 ns clock, 20 MHz.
	initial begin
		clock_in = 1'b0;
		forever #25 clock_in = ~clock_in;
	end

	// Prints the verdict and ends the run; the only place the run stops.
	task automatic give_verdict();
		if (n_fail == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Four-state compare so an unknown never passes for a match.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// One-cycle write strobe; a gap cycle follows so strobes never merge.
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask

	// Read data load at the edge after the strobe and hold until the next read, so sample just past that edge.
	task automatic rdchk(input logic [3:0] a, input logic [15:0] exp, input string what);
		@(posedge clock_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1;
		rval = rdata_out;
		chk(rval, exp, what);
	endtask

	// Counts high cycles of each pin and interrupt line, sampled mid-cycle.
	task automatic measure(input int n);
		for (int i = 0; i < 8; i++) begin
			hits[i] = 16'h0000;
		end
		repeat (n) begin
			@(negedge clock_in);
			for (int i = 0; i < 4; i++) begin
				if (pin_out[i] === 1'b1) hits[i] = hits[i] + 16'h0001;
			end
			if (period_match_irq_out === 1'b1) hits[4] = hits[4] + 16'h0001;
			for (int i = 1; i < 4; i++) begin
				if (channel_match_irq_out[i] === 1'b1) hits[4 + i] = hits[4 + i] + 16'h0001;
			end
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clock_in);
	endtask

	// A hang stops the run through the same closing task.
	initial begin
		#100000;
		n_fail++;
		$display("unexpected at %0t: watchdog expired", $time);
		give_verdict();
	end

	// Main sequence: reset values, PWM, buffering, polarity, one-shot, event clock.
	initial begin
		n_fail = 0;
		compares = 0;
		nrst_in = 1'b0;
		addr_in = 4'h0;
		wdata_in = 16'h0000;
		wr_in = 1'b0;
		rd_in = 1'b0;
		event_in = 1'b0;
		trigger_in = 1'b0;
		repeat (16) @(posedge clock_in);
		nrst_in <= 1'b1;
		rdchk(tpo_pkg::OFS_CTL0, 16'h0000, "control reset");
		rdchk(tpo_pkg::OFS_IOC0, 16'h0000, "pin control reset");
		rdchk(tpo_pkg::OFS_CCR0, 16'h0000, "period compare reset");
		rdchk(tpo_pkg::OFS_CNT, 16'hFFFF, "counter reset");
		rdchk(4'hB, 16'h0000, "unmapped read");
		// Period 5 clocks: output one 2/5, output two 0%, output three 100%.
		wr(tpo_pkg::OFS_IOC0, 16'h0055);
		wr(tpo_pkg::OFS_CCR0, 16'h0004);
		wr(tpo_pkg::OFS_CCR0 + 4'h2, 16'h0000);
		wr(tpo_pkg::OFS_CCR3, 16'h0005);
		wr(tpo_pkg::OFS_CCR0 + 4'h1, 16'h0002);
		wr(tpo_pkg::OFS_CTL1, 16'h0004);
		rdchk(tpo_pkg::OFS_CCR0 + 4'h1, 16'h0002, "compare one readback");
		wr(tpo_pkg::OFS_CTL0, 16'h0080);
		idle(10);
		measure(50);
		chk(hits[1], 16'd20, "output one duty");
		chk(hits[2], 16'd0, "output two zero duty");
		chk(hits[3], 16'd50, "output three full duty");
		chk(hits[0], 16'd25, "toggle output");
		chk(hits[4], 16'd10, "period interrupts");
		chk(hits[5], 16'd10, "channel one interrupts");
		chk(hits[6], 16'h000A, "channel two interrupts at count zero");
		chk(hits[7], 16'd0, "channel three never matches");
		// The count is 0000H two edges after the enable lands; 58 ticks later it shows 3.
		rdchk(tpo_pkg::OFS_CNT, 16'h0003, "counter below period");
		// A read inside a running period must show a count no higher than the period compare.
		chk(16'(rval <= 16'h0004), 16'h0001, "live counter range");
		// Channel two waits for a channel one write; the unused registers do nothing.
		wr(tpo_pkg::OFS_CCR0 + 4'h2, 16'h0003);
		wr(tpo_pkg::OFS_IOC1, 16'h00FF);
		wr(tpo_pkg::OFS_OPT0, 16'h00FF);
		idle(20);
		measure(50);
		chk(hits[2], 16'd0, "channel two held back");
		chk(hits[1], 16'd20, "output one unchanged");
		wr(tpo_pkg::OFS_CCR0 + 4'h1, 16'h0002);
		idle(15);
		measure(50);
		chk(hits[2], 16'd30, "channel two after arm");
		// Output one active low, two and three off, output zero parked high.
		wr(tpo_pkg::OFS_IOC0, 16'h000E);
		idle(5);
		measure(50);
		chk(hits[0], 16'd50, "output zero static level");
		chk(hits[1], 16'd30, "output one inverted");
		chk(hits[2], 16'd0, "output two disabled");
		chk(hits[3], 16'd0, "output three disabled");
		chk({12'h000, pin_oe_out}, 16'h0003, "pin enables");
		// A duty change on output one alone needs only its own compare write.
		wr(tpo_pkg::OFS_CCR0 + 4'h1, 16'h0001);
		idle(15);
		measure(50);
		chk(hits[1], 16'h0028, "output one duty alone, inverted");
		// One-shot: set the edge after count 2, cleared the edge after count 6, so 4 cycles.
		wr(tpo_pkg::OFS_CTL0, 16'h0000);
		wr(tpo_pkg::OFS_CTL1, 16'h0003);
		wr(tpo_pkg::OFS_CCR0, 16'h0006);
		wr(tpo_pkg::OFS_CCR0 + 4'h1, 16'h0002);
		wr(tpo_pkg::OFS_IOC0, 16'h0005);
		wr(tpo_pkg::OFS_IOC2, 16'h0001);
		wr(tpo_pkg::OFS_CTL0, 16'h0080);
		idle(5);
		wr(tpo_pkg::OFS_CTL1, 16'h0043);
		measure(30);
		chk(hits[1], 16'h0004, "one-shot width");
		chk(hits[4], 16'd1, "one-shot period interrupt");
		chk(hits[5], 16'd1, "one-shot channel interrupt");
		rdchk(tpo_pkg::OFS_CNT, 16'hFFFF, "one-shot stopped");
		@(posedge clock_in);
		trigger_in <= 1'b1;
		measure(30);
		chk(hits[1], 16'h0004, "external trigger pulse");
		trigger_in <= 1'b0;
		// Event clock selected in the enabling write: four rising edges give 0 to 3.
		wr(tpo_pkg::OFS_CTL0, 16'h0000);
		wr(tpo_pkg::OFS_CTL1, 16'h0004);
		wr(tpo_pkg::OFS_CCR0, 16'h0064);
		wr(tpo_pkg::OFS_IOC2, 16'h0004);
		wr(tpo_pkg::OFS_CTL0, 16'h0087);
		idle(5);
		repeat (4) begin
			@(posedge clock_in);
			event_in <= 1'b1;
			idle(3);
			@(posedge clock_in);
			event_in <= 1'b0;
			idle(3);
		end
		idle(10);
		rdchk(tpo_pkg::OFS_CNT, 16'h0003, "event counting");
		give_verdict();
	end
endmodule
